// ---- hdl/mtmc_pkg.sv ----
// constants shared by the translation maintenance control block
// assumes a 32-bit core with big-endian bit numbering in the instruction set
package mtmc_pkg;

    // ****************************************
    // operations decoded upstream
    // ****************************************
    typedef enum logic [3:0]
    {
        MTMC_OP_NONE      = 4'h0,
        MTMC_OP_SEG_WR    = 4'h1,
        MTMC_OP_SEG_WR_IX = 4'h2,
        MTMC_OP_SEG_RD    = 4'h3,
        MTMC_OP_SEG_RD_IX = 4'h4,
        MTMC_OP_INV_ENTRY = 4'h5,
        MTMC_OP_INV_ALL   = 4'h6,
        MTMC_OP_SYNC      = 4'h7,
        MTMC_OP_LOAD_I    = 4'h8,
        MTMC_OP_LOAD_D    = 4'h9,
        MTMC_OP_SPR_WR    = 4'ha,
        MTMC_OP_SPR_RD    = 4'hb,
        MTMC_OP_MISS_I    = 4'hc,
        MTMC_OP_MISS_D    = 4'hd
    } mtmc_op_e;

    // ****************************************
    // sizes and field positions
    // ****************************************
    localparam int MTMC_SEG_COUNT    = 16;
    localparam int MTMC_BLK_COUNT    = 16;
    localparam int MTMC_SETS         = 32;
    localparam int MTMC_WAYS         = 2;
    // set index is ea[15:19] in big-endian numbering, i.e. bits 16..12 here
    localparam int MTMC_SET_LSB      = 12;
    // segment index is rB[0:3], i.e. bits 31..28 here
    localparam int MTMC_SEG_IX_LSB   = 28;
    // format select is bit 0 in big-endian numbering
    localparam int MTMC_SEG_FMT_BIT  = 31;
    localparam logic [31:0] MTMC_WORD_RESET = 32'h0000_0000;

    // ****************************************
    // special-register numbers
    // ****************************************
    localparam logic [9:0] MTMC_SPR_PTD    = 10'h019;
    localparam logic [9:0] MTMC_SPR_IBLK0  = 10'h210;
    localparam logic [9:0] MTMC_SPR_DBLK0  = 10'h218;
    localparam logic [9:0] MTMC_SPR_INSTR_ENTRY_COMPARE_REG   = 10'h3d5;
    localparam logic [9:0] MTMC_SPR_DATA_ENTRY_COMPARE_REG   = 10'h3d1;
    localparam logic [9:0] MTMC_SPR_RPA    = 10'h3da;

endpackage

// ---- hdl/mtmc_tlb_way.sv ----
// one way of a translation buffer: valid bits and two-word entries
// assumes writes and invalidates come from the control logic on the same clock
`timescale 1ns/10ps
module mtmc_tlb_way
    import mtmc_pkg::*;
#(
    parameter int SETS = MTMC_SETS
)
(
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire logic                     inv_en,
    input  wire logic [$clog2(SETS)-1:0]  inv_set,
    input  wire logic                     wr_en,
    input  wire logic [$clog2(SETS)-1:0]  wr_set,
    input  wire logic [31:0]              wr_cmp,
    input  wire logic [31:0]              wr_phys,
    input  wire logic [$clog2(SETS)-1:0]  rd_set,
    output logic                          rd_valid,
    output logic [31:0]                   rd_cmp,
    output logic [31:0]                   rd_phys
);

    logic [SETS-1:0] valid_q;
    logic [31:0]     cmp_q  [SETS];
    logic [31:0]     phys_q [SETS];

    // invalidate beats a load to the same set in one cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            valid_q <= '0;
        else
        begin
            if (wr_en)
                valid_q[wr_set] <= 1'b1;
            if (inv_en)
                valid_q[inv_set] <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            cmp_q[wr_set]  <= wr_cmp;
            phys_q[wr_set] <= wr_phys;
        end
    end

    assign rd_valid = valid_q[rd_set];
    assign rd_cmp   = cmp_q[rd_set];
    assign rd_phys  = phys_q[rd_set];

endmodule // mtmc_tlb_way

// ---- hdl/mtmc_top.sv ----
// translation maintenance control: segment, block and table registers,
// buffer invalidate, load and synchronize operations
// assumes ops arrive decoded as one-cycle pulses from the issue stage
//
// Overview of operation
// - invalidate-all is an illegal instruction
// - direct segment move uses instruction number
// - indirect segment move uses index bits 0-3
// - entry invalidate clears four entries by set
// - sync released lets execution continue
// - sync held stalls after sync completes
// - instruction load uses compare and physical
// - data load uses compare and physical
// - sixteen 32-bit segment registers, moves only
// - segment bit 0 selects decode format
// - sixteen block registers, instruction and data
// - block registers 32-bit, special moves
// - 32-bit page table descriptor register
// - these registers supervisor only
// - miss loads compare register automatically
`timescale 1ns/10ps
module mtmc_top
    import mtmc_pkg::*;
#(
    parameter int SETS = MTMC_SETS
)
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        op_valid,
    input  wire logic [3:0]  op_code,
    input  wire logic        op_supervisor,
    input  wire logic [3:0]  op_seg_num,
    input  wire logic [9:0]  op_spr_num,
    input  wire logic [31:0] op_src,
    input  wire logic [31:0] op_index,
    input  wire logic [31:0] miss_compare_word,
    input  wire logic        translation_sync_hold_in,
    input  wire logic [31:0] xlate_ea,
    output logic             op_done,
    output logic [31:0]      op_result,
    output logic             illegal_trap,
    output logic             privilege_trap,
    output logic             exec_stall,
    output logic [31:0]      xlate_segment,
    output logic             xlate_seg_direct_store,
    output logic             instr_hit,
    output logic             data_hit,
    output logic [31:0]      instr_hit_phys,
    output logic [31:0]      data_hit_phys
);

    localparam int SW = $clog2(SETS);

    // ****************************************
    // sync state machine
    // ****************************************
    typedef enum logic [1:0]
    {
        MTMC_RUN  = 2'b01,
        MTMC_HOLD = 2'b10
    } mtmc_state_e;

    mtmc_state_e state_q;
    mtmc_state_e state_d;

    logic [31:0] segment_regs              [MTMC_SEG_COUNT];
    logic [31:0] instr_block_upper_regs    [4];
    logic [31:0] instr_block_lower_regs    [4];
    logic [31:0] data_block_upper_regs     [4];
    logic [31:0] data_block_lower_regs     [4];
    logic [31:0] page_table_descriptor_reg;
    logic [31:0] instr_entry_compare_reg;
    logic [31:0] data_entry_compare_reg;
    logic [31:0] physical_page_staging_reg;
    logic        replace_way_i_q;
    logic        replace_way_d_q;

    // synchroniser for the external hold pin
    logic sync_meta_q;
    logic sync_hold_q;

    // ****************************************
    // decode
    // ****************************************
    logic        go;
    logic        privileged_op;
    logic        priv_ok;
    logic        is_seg_wr;
    logic        is_seg_rd;
    logic [3:0]  seg_sel;
    logic        is_spr_wr;
    logic        is_spr_rd;
    logic        spr_iblk;
    logic        spr_dblk;
    logic [1:0]  blk_pair;
    logic        blk_lower;
    logic        do_inv;
    logic        do_load_i;
    logic        do_load_d;
    logic [SW-1:0] inv_set;
    logic [SW-1:0] ea_set;
    logic        sync_req;
    logic [31:0] spr_read;
    logic [31:0] blk_read;

    assign go        = op_valid && (state_q == MTMC_RUN);
    // every op of this block is privileged except the no-op, the illegal one and miss entry
    assign privileged_op = !(op_code inside {MTMC_OP_NONE, MTMC_OP_INV_ALL,
                                             MTMC_OP_MISS_I, MTMC_OP_MISS_D});
    assign priv_ok   = op_supervisor || !privileged_op;
    assign is_seg_wr = go && priv_ok && (op_code == MTMC_OP_SEG_WR
                                      || op_code == MTMC_OP_SEG_WR_IX);
    assign is_seg_rd = (op_code == MTMC_OP_SEG_RD || op_code == MTMC_OP_SEG_RD_IX);
    assign seg_sel   = (op_code == MTMC_OP_SEG_WR_IX || op_code == MTMC_OP_SEG_RD_IX)
                     ? op_index[MTMC_SEG_IX_LSB +: 4]
                     : op_seg_num;
    assign is_spr_wr = go && priv_ok && (op_code == MTMC_OP_SPR_WR);
    assign is_spr_rd = (op_code == MTMC_OP_SPR_RD);
    assign spr_iblk  = (op_spr_num[9:3] == MTMC_SPR_IBLK0[9:3]);
    assign spr_dblk  = (op_spr_num[9:3] == MTMC_SPR_DBLK0[9:3]);
    assign blk_pair  = op_spr_num[2:1];
    assign blk_lower = op_spr_num[0];
    assign do_inv    = go && priv_ok && (op_code == MTMC_OP_INV_ENTRY);
    assign inv_set   = op_index[MTMC_SET_LSB +: SW];
    assign ea_set    = xlate_ea[MTMC_SET_LSB +: SW];
    assign do_load_i = go && priv_ok && (op_code == MTMC_OP_LOAD_I);
    assign do_load_d = go && priv_ok && (op_code == MTMC_OP_LOAD_D);
    assign sync_req  = go && priv_ok && (op_code == MTMC_OP_SYNC);

    assign blk_read = spr_iblk ? (blk_lower ? instr_block_lower_regs[blk_pair]
                                            : instr_block_upper_regs[blk_pair])
                               : (blk_lower ? data_block_lower_regs[blk_pair]
                                            : data_block_upper_regs[blk_pair]);
    assign spr_read = (spr_iblk || spr_dblk)            ? blk_read :
                      (op_spr_num == MTMC_SPR_PTD)       ? page_table_descriptor_reg :
                      (op_spr_num == MTMC_SPR_INSTR_ENTRY_COMPARE_REG)      ? instr_entry_compare_reg :
                      (op_spr_num == MTMC_SPR_DATA_ENTRY_COMPARE_REG)      ? data_entry_compare_reg :
                      (op_spr_num == MTMC_SPR_RPA)       ? physical_page_staging_reg :
                                                           MTMC_WORD_RESET;

    // ****************************************
    // sync hold
    // ****************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync_meta_q <= 1'b0;
            sync_hold_q <= 1'b0;
        end
        else
        begin
            sync_meta_q <= translation_sync_hold_in;
            sync_hold_q <= sync_meta_q;
        end
    end

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            MTMC_RUN:
                if (sync_req && sync_hold_q)
                    state_d = MTMC_HOLD;
            MTMC_HOLD:
                if (!sync_hold_q)
                    state_d = MTMC_RUN;
            default:
                state_d = MTMC_RUN;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state_q <= MTMC_RUN;
        else
            state_q <= state_d;
    end

    // ****************************************
    // architected registers
    // ****************************************
    // segment writes land at the edge ending the op, so any later lookup sees them
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < MTMC_SEG_COUNT; i++)
                segment_regs[i] <= MTMC_WORD_RESET;
        end
        else if (is_seg_wr)
            segment_regs[seg_sel] <= op_src;
    end

    // block registers clear at reset, though software must not rely on it
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (int i = 0; i < 4; i++)
            begin
                instr_block_upper_regs[i] <= MTMC_WORD_RESET;
                instr_block_lower_regs[i] <= MTMC_WORD_RESET;
                data_block_upper_regs[i]  <= MTMC_WORD_RESET;
                data_block_lower_regs[i]  <= MTMC_WORD_RESET;
            end
        end
        else if (is_spr_wr && spr_iblk)
        begin
            if (blk_lower)
                instr_block_lower_regs[blk_pair] <= op_src;
            else
                instr_block_upper_regs[blk_pair] <= op_src;
        end
        else if (is_spr_wr && spr_dblk)
        begin
            if (blk_lower)
                data_block_lower_regs[blk_pair] <= op_src;
            else
                data_block_upper_regs[blk_pair] <= op_src;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            page_table_descriptor_reg <= MTMC_WORD_RESET;
            physical_page_staging_reg <= MTMC_WORD_RESET;
            instr_entry_compare_reg   <= MTMC_WORD_RESET;
            data_entry_compare_reg    <= MTMC_WORD_RESET;
        end
        else if (go)
        begin
            if (is_spr_wr && op_spr_num == MTMC_SPR_PTD)
                page_table_descriptor_reg <= op_src;
            if (is_spr_wr && op_spr_num == MTMC_SPR_RPA)
                physical_page_staging_reg <= op_src;
            if (op_code == MTMC_OP_MISS_I)
                instr_entry_compare_reg <= miss_compare_word;
            if (op_code == MTMC_OP_MISS_D)
                data_entry_compare_reg <= miss_compare_word;
        end
    end

    // ****************************************
    // translation buffers
    // ****************************************
    logic [MTMC_WAYS-1:0] i_valid;
    logic [MTMC_WAYS-1:0] d_valid;
    logic [31:0]          i_cmp  [MTMC_WAYS];
    logic [31:0]          i_phys [MTMC_WAYS];
    logic [31:0]          d_cmp  [MTMC_WAYS];
    logic [31:0]          d_phys [MTMC_WAYS];
    logic [SW-1:0]        i_wr_set;
    logic [SW-1:0]        d_wr_set;

    // load set comes from the effective address in the op's index operand, bits 16..12
    assign i_wr_set = op_index[MTMC_SET_LSB +: SW];
    assign d_wr_set = op_index[MTMC_SET_LSB +: SW];

    for (genvar w = 0; w < MTMC_WAYS; w++)
    begin : g_way
        mtmc_tlb_way #(.SETS(SETS)) u_instr_translation_buffer
        (
            .clk      (clk),
            .rst      (rst),
            .inv_en   (do_inv),
            .inv_set  (inv_set),
            .wr_en    (do_load_i && (replace_way_i_q == 1'(w))),
            .wr_set   (i_wr_set),
            .wr_cmp   (instr_entry_compare_reg),
            .wr_phys  (physical_page_staging_reg),
            .rd_set   (ea_set),
            .rd_valid (i_valid[w]),
            .rd_cmp   (i_cmp[w]),
            .rd_phys  (i_phys[w])
        );
        mtmc_tlb_way #(.SETS(SETS)) u_data_translation_buffer
        (
            .clk      (clk),
            .rst      (rst),
            .inv_en   (do_inv),
            .inv_set  (inv_set),
            .wr_en    (do_load_d && (replace_way_d_q == 1'(w))),
            .wr_set   (d_wr_set),
            .wr_cmp   (data_entry_compare_reg),
            .wr_phys  (physical_page_staging_reg),
            .rd_set   (ea_set),
            .rd_valid (d_valid[w]),
            .rd_cmp   (d_cmp[w]),
            .rd_phys  (d_phys[w])
        );
    end

    // simple alternating replacement; a real policy would track use
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            replace_way_i_q <= 1'b0;
            replace_way_d_q <= 1'b0;
        end
        else
        begin
            if (do_load_i)
                replace_way_i_q <= !replace_way_i_q;
            if (do_load_d)
                replace_way_d_q <= !replace_way_d_q;
        end
    end

    // ****************************************
    // lookup view for the translation path
    // ****************************************
    logic [31:0] cur_seg;
    logic        i_h0;
    logic        i_h1;
    logic        d_h0;
    logic        d_h1;

    assign cur_seg = segment_regs[xlate_ea[MTMC_SEG_IX_LSB +: 4]];
    assign i_h0 = i_valid[0] && (i_cmp[0][23:0] == cur_seg[23:0]);
    assign i_h1 = i_valid[1] && (i_cmp[1][23:0] == cur_seg[23:0]);
    assign d_h0 = d_valid[0] && (d_cmp[0][23:0] == cur_seg[23:0]);
    assign d_h1 = d_valid[1] && (d_cmp[1][23:0] == cur_seg[23:0]);

    // ****************************************
    // outputs
    // ****************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            op_done                <= 1'b0;
            op_result              <= MTMC_WORD_RESET;
            illegal_trap           <= 1'b0;
            privilege_trap         <= 1'b0;
            exec_stall             <= 1'b0;
            xlate_segment          <= MTMC_WORD_RESET;
            xlate_seg_direct_store <= 1'b0;
            instr_hit              <= 1'b0;
            data_hit               <= 1'b0;
            instr_hit_phys         <= MTMC_WORD_RESET;
            data_hit_phys          <= MTMC_WORD_RESET;
        end
        else
        begin
            op_done        <= go && priv_ok && (op_code != MTMC_OP_INV_ALL)
                              && (op_code != MTMC_OP_NONE);
            illegal_trap   <= go && (op_code == MTMC_OP_INV_ALL);
            privilege_trap <= go && !priv_ok;
            exec_stall     <= (state_d == MTMC_HOLD);
            if (go && priv_ok && is_seg_rd)
                op_result <= segment_regs[seg_sel];
            else if (go && priv_ok && is_spr_rd)
                op_result <= spr_read;
            xlate_segment          <= cur_seg;
            xlate_seg_direct_store <= cur_seg[MTMC_SEG_FMT_BIT];
            instr_hit      <= i_h0 || i_h1;
            data_hit       <= d_h0 || d_h1;
            instr_hit_phys <= i_h1 ? i_phys[1] : i_phys[0];
            data_hit_phys  <= d_h1 ? d_phys[1] : d_phys[0];
        end
    end

endmodule // mtmc_top

// ---- verif/mtmc_sync_agent.sv ----
// system-side model driving the translation sync hold pin
// assumes the bench raises hold_req at its clock edge; lag 0..3 cycles
`timescale 1ns/10ps
module mtmc_sync_agent
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       hold_req,
    input  wire logic [1:0] lag,
    output logic            translation_sync_hold_in
);
    logic [2:0] line_q;
    logic [2:0] line_d;

    assign line_d = {line_q[1:0], hold_req};

    always_ff @(posedge clk or posedge rst)
        if (rst)
            line_q <= 3'h0;
        else
            line_q <= line_d;

    // a slow system answers some cycles after it decides to hold
    assign translation_sync_hold_in = (lag == 2'h0) ? hold_req : line_q[lag - 2'h1];
endmodule // mtmc_sync_agent

// ---- verif/mtmc_properties.sv ----
// concurrent checks on the ports of the maintenance control block
// assumes one clock and the asynchronous active-high reset
`timescale 1ns/10ps
module mtmc_chk
    import mtmc_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        op_valid,
    input wire logic [3:0]  op_code,
    input wire logic        op_supervisor,
    input wire logic        translation_sync_hold_in,
    input wire logic        op_done,
    input wire logic [31:0] op_result,
    input wire logic        illegal_trap,
    input wire logic        privilege_trap,
    input wire logic        exec_stall,
    input wire logic [31:0] xlate_segment,
    input wire logic        xlate_seg_direct_store
);
    logic take;
    logic priv_op;
    logic hold;
    logic sync_go;

    // stall equals the hold state, so take is the design's own gate
    assign take    = op_valid && !exec_stall;
    assign hold    = translation_sync_hold_in;
    assign sync_go = take && op_supervisor && op_code == MTMC_OP_SYNC;
    assign priv_op = op_code inside {[MTMC_OP_SEG_WR:MTMC_OP_INV_ENTRY],
                                     [MTMC_OP_LOAD_I:MTMC_OP_SPR_RD]};

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    illegal_op_a: assert property (take && op_code == MTMC_OP_INV_ALL
        |=> illegal_trap && !op_done) else $error("invalidate-all not trapped");
    user_trap_a: assert property (take && !op_supervisor && priv_op
        |=> privilege_trap && !op_done) else $error("user op not trapped");
    super_done_a: assert property (take && op_supervisor && priv_op
        |=> op_done && !privilege_trap) else $error("supervisor op not completed");
    write_keep_a: assert property (take && op_code inside {MTMC_OP_SEG_WR, MTMC_OP_SPR_WR}
        |=> $stable(op_result)) else $error("write disturbed read result");
    sync_free_a: assert property ((!hold)[*3] ##0 sync_go
        |=> op_done && !exec_stall ##1 !exec_stall) else $error("sync stalled without hold");
    sync_hold_a: assert property (hold[*3] ##0 sync_go
        |=> op_done && exec_stall) else $error("sync did not stall under hold");
    stall_refuse_a: assert property (hold[*3] ##0 (exec_stall && op_valid)
        |=> !op_done && !illegal_trap && !privilege_trap)
        else $error("op answered while stalled");
    stall_release_a: assert property ($fell(hold) |-> ##[1:5] !exec_stall)
        else $error("stall outlived hold release");
    stall_cause_a: assert property ($rose(exec_stall) |-> $past(sync_go))
        else $error("stall without sync");
    fmt_bit_a: assert property (xlate_seg_direct_store == xlate_segment[MTMC_SEG_FMT_BIT])
        else $error("format bit mismatch");
endmodule // mtmc_chk

bind mtmc_top mtmc_chk i_mtmc_chk (.*);

// ---- verif/test_mmu_tlb_maintenance_control.sv ----
// self-checking bench for the maintenance control block
// assumes package, design, agent and checker compiled first
`timescale 1ns/10ps
module test_mmu_tlb_maintenance_control
    import mtmc_pkg::*;
;
    typedef struct packed {logic [2:0] kind; logic chk; logic [31:0] res;} mtmc_note_s;
    localparam logic [2:0] DN = 3'h4;
    localparam logic [2:0] IL = 3'h2;
    localparam logic [2:0] PV = 3'h1;
    logic        clk, rst, op_valid, op_supervisor, hold_req, translation_sync_hold_in;
    logic        op_done, illegal_trap, privilege_trap, exec_stall, xlate_seg_direct_store;
    logic        instr_hit, data_hit;
    logic [1:0]  lag;
    logic [3:0]  op_code, op_seg_num;
    logic [9:0]  op_spr_num;
    logic [31:0] op_src, op_index, miss_compare_word, xlate_ea, seed, op_result;
    logic [31:0] xlate_segment, instr_hit_phys, data_hit_phys;
    logic [31:0] seg [16];
    logic [31:0] spr_val [17];
    logic [3:0]  ucodes [7] = '{MTMC_OP_SEG_WR, MTMC_OP_SEG_WR_IX, MTMC_OP_SEG_RD,
                  MTMC_OP_SEG_RD_IX, MTMC_OP_INV_ENTRY, MTMC_OP_SPR_WR, MTMC_OP_SPR_RD};
    mtmc_note_s  notes [$];
    mtmc_note_s  nt;
    int          err_total, comparisons, cycles, i, n;

    mtmc_top i_mtmc_top (.*);
    mtmc_sync_agent i_mtmc_sync_agent (.*);

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [9:0] spr_of(input int k);
        return (k < 16) ? MTMC_SPR_IBLK0 + 10'(k) : MTMC_SPR_PTD;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic issue(input logic [3:0] c, input logic sup, input logic [31:0] src, idx,
                         input logic [9:0] spr, input logic [2:0] k, input logic [31:0] res);
        op_valid <= 1'b1;
        op_code <= c;
        op_supervisor <= sup;
        op_src <= src;
        miss_compare_word <= src;
        op_spr_num <= spr;
        op_seg_num <= idx[31:28];
        // direct moves see a misleading index so a wrong select shows up
        op_index <= (c == MTMC_OP_SEG_RD || c == MTMC_OP_SEG_WR) ? ~idx : idx;
        if (k != 3'h0)
            notes.push_back('{k, k == DN && c inside {MTMC_OP_SEG_RD, MTMC_OP_SEG_RD_IX,
                             MTMC_OP_SPR_RD}, res});
        @(posedge clk);
    endtask

    task automatic idle(input int c);
        op_valid <= 1'b0;
        repeat (c) @(posedge clk);
    endtask

    task automatic look(input logic [3:0] k);
        xlate_ea <= {k, 28'h000_0000};
        idle(2);
        @(negedge clk);
        check(xlate_segment, seg[k]);
        check(xlate_seg_direct_store, seg[k][31]);
        @(posedge clk);
    endtask

    task automatic hits(input logic [1:0] e);
        xlate_ea <= 32'h0001_5000;
        idle(2);
        @(negedge clk);
        check({instr_hit, data_hit}, e);
        check(instr_hit_phys, 32'h0004_2193);
        check(data_hit_phys, 32'h0004_2193);
        @(posedge clk);
    endtask

    task automatic sync_run(input logic [1:0] l, input logic h);
        lag <= l;
        hold_req <= h;
        idle(6);
        issue(MTMC_OP_SYNC, 1'b1, 32'h0, 32'h0, 10'h0, DN, 32'h0);
        idle(2);
        @(negedge clk);
        check(exec_stall, h);
        @(posedge clk);
        // under hold this read must vanish without an answer
        issue(MTMC_OP_SEG_RD, 1'b1, 32'h0, 32'h0, 10'h0, h ? 3'h0 : DN, seg[0]);
        idle(3);
        hold_req <= 1'b0;
        for (n = 0; n < 12 && exec_stall !== 1'b0; n++)
            @(negedge clk);
        check(n < 12, 1'b1);
        @(posedge clk);
        issue(MTMC_OP_SEG_RD_IX, 1'b1, 32'h0, 32'h0, 10'h0, DN, seg[0]);
        idle(2);
    endtask

    // ****************************************
    // answer monitor and watchdog
    // ****************************************
    always @(negedge clk)
        if (!rst && (op_done | illegal_trap | privilege_trap) !== 1'b0)
        begin
            nt = (notes.size() > 0) ? notes.pop_front() : '0;
            check({op_done, illegal_trap, privilege_trap}, nt.kind);
            if (nt.chk)
                check(op_result, nt.res);
        end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            err_total++;
            conclude();
        end
    end

    initial
    begin
        {op_valid, op_supervisor, hold_req, lag, op_code, op_seg_num, op_spr_num} = '0;
        {op_src, op_index, miss_compare_word, xlate_ea} = '0;
        seed = 32'hb4ea_b583;
        rst = 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 16; i++)
        begin
            seed = xs(seed);
            seg[i] = seed;
            issue(MTMC_OP_SEG_WR, 1'b1, seed, {i[3:0], 28'h0}, 10'h0, DN, 32'h0);
        end
        for (i = 0; i < 16; i++)
            issue(MTMC_OP_SEG_RD_IX, 1'b1, 32'h0, {i[3:0], 28'h0}, 10'h0, DN, seg[i]);
        for (i = 0; i < 16; i++)
            issue(MTMC_OP_SEG_RD, 1'b1, 32'h0, {i[3:0], 28'h0}, 10'h0, DN, seg[i]);
        for (i = 0; i < 17; i++)
        begin
            seed = xs(seed);
            spr_val[i] = seed;
            issue(MTMC_OP_SPR_WR, 1'b1, seed, 32'h0, spr_of(i), DN, 32'h0);
        end
        for (i = 0; i < 17; i++)
            issue(MTMC_OP_SPR_RD, 1'b1, 32'h0, 32'h0, spr_of(i), DN, spr_val[i]);
        for (i = 0; i < 7; i++)
            issue(ucodes[i], 1'b0, 32'h5a5a_5a5a, 32'h5000_0000, MTMC_SPR_PTD, PV, 32'h0);
        issue(MTMC_OP_SEG_RD_IX, 1'b1, 32'h0, 32'h5000_0000, 10'h0, DN, seg[5]);
        issue(MTMC_OP_SPR_RD, 1'b1, 32'h0, 32'h0, MTMC_SPR_PTD, DN, spr_val[16]);
        issue(MTMC_OP_INV_ALL, 1'b1, 32'h0, 32'h0, 10'h0, IL, 32'h0);
        issue(MTMC_OP_INV_ALL, 1'b0, 32'h0, 32'h0, 10'h0, IL, 32'h0);
        issue(MTMC_OP_NONE, 1'b1, 32'h0, 32'h0, 10'h0, 3'h0, 32'h0);
        seed = {~seg[0][31:24], seg[0][23:0]};
        issue(MTMC_OP_MISS_I, 1'b1, seg[0], 32'h0, 10'h0, DN, 32'h0);
        issue(MTMC_OP_MISS_D, 1'b1, seed, 32'h0, 10'h0, DN, 32'h0);
        issue(MTMC_OP_SPR_RD, 1'b1, 32'h0, 32'h0, MTMC_SPR_INSTR_ENTRY_COMPARE_REG, DN, seg[0]);
        issue(MTMC_OP_SPR_RD, 1'b1, 32'h0, 32'h0, MTMC_SPR_DATA_ENTRY_COMPARE_REG, DN, seed);
        issue(MTMC_OP_SPR_WR, 1'b1, 32'h0004_2193, 32'h0, MTMC_SPR_RPA, DN, 32'h0);
        issue(MTMC_OP_SPR_RD, 1'b1, 32'h0, 32'h0, MTMC_SPR_RPA, DN, 32'h0004_2193);
        issue(MTMC_OP_LOAD_I, 1'b1, 32'h0, 32'h0001_5000, 10'h0, DN, 32'h0);
        issue(MTMC_OP_LOAD_D, 1'b1, 32'h0, 32'h0001_5000, 10'h0, DN, 32'h0);
        issue(MTMC_OP_LOAD_I, 1'b0, 32'h0, 32'h0001_5000, 10'h0, PV, 32'h0);
        hits(2'b11);
        issue(MTMC_OP_INV_ENTRY, 1'b1, 32'h0, 32'h0001_5000, 10'h0, DN, 32'h0);
        hits(2'b00);
        issue(MTMC_OP_SEG_WR, 1'b1, ~seg[9], 32'h9000_0000, 10'h0, DN, 32'h0);
        seg[9] = ~seg[9];
        look(4'h9);
        for (i = 0; i < 16; i += 5)
            look(i[3:0]);
        sync_run(2'h0, 1'b0);
        sync_run(2'h0, 1'b1);
        sync_run(2'h2, 1'b1);
        idle(3);
        check(notes.size(), 32'h0);
        conclude();
    end
endmodule // test_mmu_tlb_maintenance_control
